// file: core/pcig_glue.sv
`timescale 1ns/100ps
`default_nettype none
module pcig_glue
	import pcig_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [31:0] ad_in,
	output logic      [31:0] ad_out,
	output logic             ad_oe,
	input  wire logic [3:0]  cbe_n_in,
	output logic      [3:0]  cbe_n_out,
	output logic             cbe_n_oe,
	input  wire logic        frame_n_in,
	output logic             frame_n_out,
	output logic             frame_n_oe,
	input  wire logic        irdy_n_in,
	output logic             irdy_n_out,
	output logic             irdy_n_oe,
	input  wire logic        trdy_n_in,
	output logic             trdy_n_out,
	output logic             trdy_n_oe,
	input  wire logic        devsel_n_in,
	output logic             devsel_n_out,
	output logic             devsel_n_oe,
	input  wire logic        stop_n_in,
	output logic             stop_n_out,
	output logic             stop_n_oe,
	input  wire logic        idsel,
	input  wire logic        gnt_n,
	output logic             req_n,
	input  wire logic        m66en,
	output logic             bus_66mhz,
	output logic             inta_n_out,
	output logic             inta_n_oe,
	input  wire logic [23:0] io_base,
	input  wire logic [23:0] mem_base,
	input  wire logic        endian_big,
	input  wire logic        dac_enable,
	input  wire logic [7:0]  irq_src,
	input  wire logic        mst_start,
	input  wire logic [63:0] mst_addr,
	input  wire logic        mst_write,
	input  wire logic [7:0]  mst_count,
	input  wire logic [31:0] mst_wdata,
	output logic             mst_wnext,
	output logic      [31:0] mst_rdata,
	output logic             mst_rvalid,
	output logic             mst_busy,
	output logic             mst_done,
	output logic             mst_abort
);

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	pcig_pins_t pin_raw;    // bus inputs as they arrive
	pcig_pins_t pin_meta;   // first stage, read only by pin_s
	pcig_pins_t pin_s;      // safe copy for all logic
	logic       frame_prev; // frame one cycle earlier, for edge find

	assign pin_raw = {frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in, stop_n_in,
		gnt_n, idsel, m66en, cbe_n_in, ad_in};

	// two stages, then one more for the address phase edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta   <= PINS_IDLE;
			pin_s      <= PINS_IDLE;
			frame_prev <= 1'b1;
		end else begin
			pin_meta   <= pin_raw;
			pin_s      <= pin_meta;
			frame_prev <= pin_s.frame_n;
		end
	end

	// speed strap only reported; the logic is the same at both rates
	assign bus_66mhz = pin_s.m66en;

	// ****************************************************************
	// target side and registers
	// ****************************************************************
	pcig_tstate_t t_state, next_t_state;
	pcig_mstate_t m_state;
	logic [3:0]   t_cmd, next_t_cmd;     // command of the claimed cycle
	logic [31:0]  t_addr, next_t_addr;   // address of the claimed cycle
	logic [31:0]  t_data, next_t_data;   // read data held for the bus
	logic [7:0]   interrupt_status_register, next_isr;         // interrupt_status_register
	logic [31:0]  interrupt_mask_register, next_imr;         // interrupt_mask_register
	logic [7:0]   latency_timer_register, next_ltr;         // latency_timer_register
	logic         frame_fall;            // address phase seen
	logic         t_cfg;                 // claimed cycle is a config cycle
	logic         t_rd;                  // claimed cycle reads from us
	logic [31:0]  wdata;                 // write data in register order
	logic [7:0]   isr_clr;               // ones written to the status

	// claim test: only single address commands are decoded here
	function automatic logic pcig_claim(input logic [3:0] cmd, input logic [31:0] a,
		input logic sel, input logic [23:0] iob, input logic [23:0] memb);
		case (cmd)
			CMD_IO_RD, CMD_IO_WR:   pcig_claim = a[31:DEC_LSB] == iob;
			CMD_MEM_RD, CMD_MEM_WR: pcig_claim = a[31:DEC_LSB] == memb;
			CMD_CFG_RD, CMD_CFG_WR: pcig_claim = sel && a[1:0] == 2'b00;
			default:                pcig_claim = 1'b0;
		endcase
	endfunction

	assign frame_fall = frame_prev && !pin_s.frame_n && m_state == M_IDLE;
	assign t_cfg = t_cmd == CMD_CFG_RD || t_cmd == CMD_CFG_WR;
	assign t_rd  = t_cmd == CMD_IO_RD || t_cmd == CMD_MEM_RD || t_cmd == CMD_CFG_RD;
	// config data stays in little order whatever the lane setting
	assign wdata = t_cfg ? pin_s.ad : pcig_lanes(pin_s.ad, endian_big);

	// next target state, register reads and writes
	always_comb begin
		next_t_state = t_state;
		next_t_cmd   = t_cmd;
		next_t_addr  = t_addr;
		next_t_data  = t_data;
		next_imr     = interrupt_mask_register;
		next_ltr     = latency_timer_register;
		isr_clr      = 8'h00;
		case (t_state)
			T_IDLE: begin
				if (frame_fall && pcig_claim(pin_s.cbe_n, pin_s.ad, pin_s.idsel,
					io_base, mem_base)) begin
					next_t_state = T_WAIT;
					next_t_cmd   = pin_s.cbe_n;
					next_t_addr  = pin_s.ad;
				end
			end
			T_WAIT: begin
				// read value in bus lane order
				if (t_cfg) begin
					next_t_data = t_addr[7:2] == CFG_DW_LAT ?
						{16'h0000, latency_timer_register, 8'h00} : 32'h00000000;
				end else if (t_addr[7:0] == OFS_ISR) begin
					next_t_data = pcig_lanes({24'h000000, interrupt_status_register}, endian_big);
				end else if (t_addr[7:0] == OFS_IMR) begin
					next_t_data = pcig_lanes(interrupt_mask_register, endian_big);
				end else begin
					next_t_data = 32'h00000000;
				end
				if (!pin_s.irdy_n) begin
					next_t_state = T_XFER;
					if (!t_rd && t_cfg && t_addr[7:2] == CFG_DW_LAT
						&& !pin_s.cbe_n[LTR_LANE]) begin
						next_ltr = wdata[LTR_LSB +: 8];
					end else if (!t_rd && !t_cfg && t_addr[7:0] == OFS_ISR) begin
						isr_clr = wdata[ISR_W-1:0];
					end else if (!t_rd && !t_cfg && t_addr[7:0] == OFS_IMR) begin
						next_imr = wdata;
					end
				end else if (pin_s.frame_n) begin
					next_t_state = T_IDLE;   // master gave up before data
				end
			end
			T_XFER: begin
				// one word per claim; a longer burst is disconnected
				next_t_state = pin_s.frame_n ? T_IDLE : T_HOLD;
			end
			T_HOLD: begin
				if (pin_s.frame_n) begin
					next_t_state = T_IDLE;
				end
			end
			default: next_t_state = T_IDLE;
		endcase
		// a new event wins over a clear landing in the same cycle
		next_isr = (interrupt_status_register & ~isr_clr) | irq_src;
	end

	// register only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			t_state <= T_IDLE;
			t_cmd   <= 4'h0;
			t_addr  <= 32'h00000000;
			t_data  <= 32'h00000000;
			interrupt_status_register     <= ISR_RESET;
			interrupt_mask_register     <= IMR_RESET;
			latency_timer_register     <= LTR_RESET;
		end else begin
			t_state <= next_t_state;
			t_cmd   <= next_t_cmd;
			t_addr  <= next_t_addr;
			t_data  <= next_t_data;
			interrupt_status_register     <= next_isr;
			interrupt_mask_register     <= next_imr;
			latency_timer_register     <= next_ltr;
		end
	end

	// ****************************************************************
	// interrupt pin
	// ****************************************************************
	// pure gating of register bits, no clock between condition and pin
	assign inta_n_out = 1'b0;
	assign inta_n_oe  = interrupt_mask_register[IMR_GLOBAL] && |(interrupt_status_register & interrupt_mask_register[ISR_W-1:0]);

	// ****************************************************************
	// master engine
	// ****************************************************************
	pcig_lat_if lat ();
	pcig_mstate_t next_m_state;
	logic [63:0]  m_addr, next_m_addr;     // transfer start address
	logic         m_wr, next_m_wr;         // transfer direction
	logic [7:0]   m_remain, next_m_remain; // words still to move
	logic [3:0]   m_wait, next_m_wait;     // cycles without a claim
	logic [31:0]  m_ad, next_m_ad;         // master word for the bus
	logic [3:0]   m_cbe, next_m_cbe;       // command or byte enables
	logic [31:0]  next_rdata;
	logic         next_rvalid, next_done, next_abort;
	logic         m_last;                  // current data phase is the last
	logic         m_dual;                  // this transfer needs two addresses
	logic         m_end, next_m_end;       // frame already let go in this burst

	// the timer disarms once frame drops, so the end must be held here
	assign m_last = m_remain == 8'h01 || lat.terminate || m_end;
	assign m_dual = dac_enable && m_addr[63:32] != 32'h00000000;

	// next master state
	always_comb begin
		next_m_state  = m_state;
		next_m_addr   = m_addr;
		next_m_wr     = m_wr;
		next_m_remain = m_remain;
		next_m_wait   = m_wait;
		next_m_ad     = m_ad;
		next_m_cbe    = m_cbe;
		next_rdata    = mst_rdata;
		next_rvalid   = 1'b0;
		next_done     = 1'b0;
		next_abort    = 1'b0;
		mst_wnext     = 1'b0;
		// once frame is released it must stay up until the burst ends
		next_m_end    = m_state == M_DATA && m_last;
		case (m_state)
			M_IDLE: begin
				if (mst_start && t_state == T_IDLE && mst_count != 8'h00) begin
					next_m_state  = M_REQ;
					next_m_addr   = mst_addr;
					next_m_wr     = mst_write;
					next_m_remain = mst_count;
				end
			end
			M_REQ: begin
				if (!pin_s.gnt_n && pin_s.frame_n && pin_s.irdy_n) begin
					next_m_state = M_ADDR;
					next_m_ad    = m_addr[31:0];
					next_m_cbe   = m_dual ? CMD_DUAL :
						(m_wr ? CMD_MEM_WR : CMD_MEM_RD);
				end
			end
			M_ADDR, M_ADDR_HI: begin
				if (m_state == M_ADDR && m_dual) begin
					next_m_state = M_ADDR_HI;
					next_m_ad    = m_addr[63:32];
					next_m_cbe   = m_wr ? CMD_MEM_WR : CMD_MEM_RD;
				end else begin
					next_m_state = M_DATA;
					next_m_wait  = 4'h0;
					next_m_cbe   = BE_ALL;
					next_m_ad    = pcig_lanes(mst_wdata, endian_big);
					mst_wnext    = m_wr;
				end
			end
			M_DATA: begin
				if (!pin_s.trdy_n && !pin_s.devsel_n) begin
					next_m_remain = m_remain - 8'h01;
					next_rdata    = pcig_lanes(pin_s.ad, endian_big);
					next_rvalid   = !m_wr;
					if (m_last || !pin_s.stop_n) begin
						next_m_state = M_TURN;
						next_done    = 1'b1;
					end else begin
						next_m_ad = pcig_lanes(mst_wdata, endian_big);
						mst_wnext = m_wr;
					end
				end else if (pin_s.devsel_n) begin
					next_m_wait = m_wait + 4'h1;
					if (next_m_wait == DEVSEL_WAIT) begin
						next_m_state = M_TURN;   // nobody claimed: master abort
						next_abort   = 1'b1;
					end
				end
			end
			M_TURN:  next_m_state = M_IDLE;
			default: next_m_state = M_IDLE;
		endcase
	end

	// register only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			m_state    <= M_IDLE;
			m_addr     <= 64'h0000000000000000;
			m_wr       <= 1'b0;
			m_remain   <= 8'h00;
			m_wait     <= 4'h0;
			m_end      <= 1'b0;
			m_ad       <= 32'h00000000;
			m_cbe      <= BE_ALL;
			mst_rdata  <= 32'h00000000;
			mst_rvalid <= 1'b0;
			mst_done   <= 1'b0;
			mst_abort  <= 1'b0;
		end else begin
			m_state    <= next_m_state;
			m_addr     <= next_m_addr;
			m_wr       <= next_m_wr;
			m_remain   <= next_m_remain;
			m_wait     <= next_m_wait;
			m_end      <= next_m_end;
			m_ad       <= next_m_ad;
			m_cbe      <= next_m_cbe;
			mst_rdata  <= next_rdata;
			mst_rvalid <= next_rvalid;
			mst_done   <= next_done;
			mst_abort  <= next_abort;
		end
	end

	// latency timer hookup
	assign lat.frame_start  = m_state == M_ADDR;
	assign lat.frame_active = m_state == M_ADDR || m_state == M_ADDR_HI
		|| (m_state == M_DATA && !m_last);
	assign lat.gnt_n        = pin_s.gnt_n;
	assign lat.latency_timer_register          = latency_timer_register;

	pcig_lat_timer u_lat (
		.sys_clk (sys_clk),
		.srst    (srst),
		.lat     (lat)
	);

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	assign mst_busy     = m_state != M_IDLE;
	assign req_n        = m_state != M_REQ;
	assign frame_n_oe   = m_state inside {M_ADDR, M_ADDR_HI, M_DATA, M_TURN};
	assign frame_n_out  = !(m_state inside {M_ADDR, M_ADDR_HI}
		|| (m_state == M_DATA && !m_last));
	assign irdy_n_oe    = m_state inside {M_DATA, M_TURN};
	assign irdy_n_out   = m_state != M_DATA;
	assign cbe_n_oe     = m_state inside {M_ADDR, M_ADDR_HI, M_DATA};
	assign cbe_n_out    = m_cbe;
	assign devsel_n_oe  = t_state != T_IDLE;
	assign devsel_n_out = t_state == T_IDLE;
	assign trdy_n_oe    = t_state != T_IDLE;
	assign trdy_n_out   = t_state != T_XFER;
	assign stop_n_oe    = t_state != T_IDLE;
	assign stop_n_out   = !(t_state == T_HOLD || (t_state == T_XFER && !pin_s.frame_n));
	assign ad_oe        = m_state inside {M_ADDR, M_ADDR_HI} || (m_state == M_DATA && m_wr)
		|| (t_rd && t_state inside {T_WAIT, T_XFER});
	assign ad_out       = t_state == T_IDLE ? m_ad : t_data;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_no_claim;
		(m_state == M_DATA && pin_s.devsel_n && pin_s.trdy_n)[*8];
	endsequence

	a_isr_set_wins: assert property (irq_src != 8'h00 |=> (interrupt_status_register & $past(irq_src)) == $past(irq_src))
		else $error("status event lost");
	a_isr_clear: assert property (isr_clr != 8'h00 && irq_src == 8'h00 |=> (interrupt_status_register & $past(isr_clr)) == 8'h00)
		else $error("status bit not cleared by write of one");
	a_int_global: assert property (!interrupt_mask_register[IMR_GLOBAL] |-> !inta_n_oe)
		else $error("interrupt driven with global enable off");
	a_int_release: assert property ($fell(interrupt_mask_register[IMR_GLOBAL]) |-> !inta_n_oe && inta_n_out == 1'b0)
		else $error("interrupt pin not released");
	a_no_dual_claim: assert property (frame_fall && pin_s.cbe_n == CMD_DUAL |=> t_state == T_IDLE)
		else $error("target claimed a dual address cycle");
	a_dual_addr: assert property (m_state == M_ADDR && m_cbe == CMD_DUAL |=> m_state == M_ADDR_HI ##1 m_state == M_DATA)
		else $error("dual address sequence broken");
	a_frame_stays_up: assert property (m_state == M_DATA && frame_n_out
		|=> m_state != M_DATA || frame_n_out)
		else $error("frame asserted again after release");
	a_abort_bound: assert property (s_no_claim |=> m_state == M_TURN && mst_abort)
		else $error("no abort after claim timeout");
	a_ltr_write: assert property (t_state == T_WAIT && !pin_s.irdy_n && t_cmd == CMD_CFG_WR
		&& t_addr[7:2] == CFG_DW_LAT && !pin_s.cbe_n[LTR_LANE] |=> latency_timer_register == $past(pin_s.ad[15:8]))
		else $error("latency register write lost");

endmodule
`default_nettype wire

// file: core/pcig_lat_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// master latency timer
// ****************************************************************
module pcig_lat_timer
	import pcig_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic srst,
	pcig_lat_if.tmr   lat
);

	logic [7:0] count;       // remaining bus clocks
	logic [7:0] next_count;
	logic       armed;       // timer running for the current frame
	logic       next_armed;

	// next count: load on frame start, forget on early frame release
	always_comb begin
		next_count = count;
		next_armed = armed;
		if (lat.frame_start) begin
			next_count = lat.latency_timer_register;
			next_armed = 1'b1;
		end else if (!lat.frame_active) begin
			next_armed = 1'b0;
		end else if (armed && count != 8'h00) begin
			next_count = count - 8'h01;
		end
	end

	// register only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count <= LTR_RESET;
			armed <= 1'b0;
		end else begin
			count <= next_count;
			armed <= next_armed;
		end
	end

	assign lat.expired   = armed && count == 8'h00;
	// a grant still held lets the burst run on past expiry
	assign lat.terminate = lat.expired && lat.gnt_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_lat_load: assert property (lat.frame_start |=> armed && count == $past(lat.latency_timer_register))
		else $error("latency count not loaded at frame start");
	a_lat_ignore: assert property (armed && !lat.frame_active && !lat.frame_start |=> !lat.expired)
		else $error("latency timer kept after frame release");
	a_lat_term: assert property (lat.terminate |-> $past(lat.frame_start, 1) || $past(armed))
		else $error("termination without a running timer");

endmodule
`default_nettype wire

// file: shared/pcig_lat_if.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// link between the master engine and its latency timer
// ****************************************************************
interface pcig_lat_if;
	logic       frame_start;   // one cycle as the master address goes out
	logic       frame_active;  // master still holding frame asserted
	logic       gnt_n;         // synchronised grant, low = granted
	logic [7:0] latency_timer_register;           // programmed latency count
	logic       expired;       // count has run out during this frame
	logic       terminate;     // expired and grant taken away

	modport eng (output frame_start, frame_active, gnt_n, latency_timer_register, input expired, terminate);
	modport tmr (input frame_start, frame_active, gnt_n, latency_timer_register, output expired, terminate);
endinterface
`default_nettype wire

// file: shared/pcig_pkg.sv
// ****************************************************************
// host bus glue: shared constants, types and helpers
// ****************************************************************
package pcig_pkg;

	// bus commands carried on the command/byte-enable lanes
	localparam logic [3:0] CMD_IO_RD  = 4'h2;
	localparam logic [3:0] CMD_IO_WR  = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_DUAL   = 4'hD;    // dual address cycle marker
	localparam logic [3:0] BE_ALL     = 4'h0;    // all four lanes enabled (active low)

	// target register offsets inside the io / memory window
	localparam logic [7:0] OFS_ISR    = 8'h00;
	localparam logic [7:0] OFS_IMR    = 8'h04;
	// config dword holding the latency timer, and its lane
	localparam logic [5:0] CFG_DW_LAT = 6'h03;
	localparam int         LTR_LSB    = 8;
	localparam int         LTR_LANE   = 1;
	localparam int         DEC_LSB    = 8;       // window decode uses address bits 31:8

	// interrupt field layout
	localparam int          ISR_W      = 8;
	localparam int          IMR_GLOBAL = 31;
	localparam logic [7:0]  LTR_RESET  = 8'h00;
	localparam logic [31:0] IMR_RESET  = 32'h00000000;
	localparam logic [7:0]  ISR_RESET  = 8'h00;

	// cycles a master waits for a target claim before aborting
	localparam logic [3:0] DEVSEL_WAIT = 4'h8;

	// target states, one-hot
	typedef enum logic [3:0] {
		T_IDLE = 4'b0001,
		T_WAIT = 4'b0010,
		T_XFER = 4'b0100,
		T_HOLD = 4'b1000
	} pcig_tstate_t;

	// master states, one-hot
	typedef enum logic [5:0] {
		M_IDLE    = 6'b000001,
		M_REQ     = 6'b000010,
		M_ADDR    = 6'b000100,
		M_ADDR_HI = 6'b001000,
		M_DATA    = 6'b010000,
		M_TURN    = 6'b100000
	} pcig_mstate_t;

	// bus inputs as seen after the synchroniser
	typedef struct packed {
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        gnt_n;
		logic        idsel;
		logic        m66en;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} pcig_pins_t;

	// idle bus: all active-low strobes high
	localparam pcig_pins_t PINS_IDLE = '{frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1,
		devsel_n: 1'b1, stop_n: 1'b1, gnt_n: 1'b1, idsel: 1'b0, m66en: 1'b0,
		cbe_n: 4'hF, ad: 32'h00000000};

	// byte lane order: little keeps byte 0 low, big moves byte 0 to 31:24
	function automatic logic [31:0] pcig_lanes(input logic [31:0] d, input logic big);
		pcig_lanes = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction

endpackage

// file: verification/pcig_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// far side: arbiter plus a memory target at 0x2xxxxxxx
// ****************************************************************
module pcig_bus_partner
	import pcig_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        req_n,
	input  wire logic        frame_n,
	input  wire logic        irdy_n,
	input  wire logic [3:0]  cbe_n,
	input  wire logic [31:0] ad,
	input  wire logic [31:0] rd_word,
	output logic             gnt_n,
	output logic             tgt_oe,
	output logic             trdy_n,
	output logic      [31:0] ad_drv,
	output logic             ad_drv_oe,
	output logic      [3:0]  cmd_seen,
	output logic      [31:0] hi_seen,
	output logic      [31:0] wr_seen
);
	logic      frame_q = 1'b1;           // frame one edge ago
	logic      adr_q   = 1'b0;           // last edge took an address
	wire logic start   = frame_q & ~frame_n;
	initial begin
		gnt_n = 1'b1;
		tgt_oe = 1'b0;
	end
	// grant follows request; one wait state before trdy, the slow case
	always @(posedge sys_clk) begin
		gnt_n <= req_n;
		frame_q <= frame_n;
		adr_q <= start;
		if (start) begin
			cmd_seen <= cbe_n;
			tgt_oe <= (ad[31:28] == 4'h2);
		end
		if (adr_q && cmd_seen == CMD_DUAL) begin
			hi_seen <= ad;
		end
		if (tgt_oe && !adr_q && !irdy_n) begin
			if (cmd_seen[0]) begin
				wr_seen <= ad;
			end
			if (frame_n) begin
				tgt_oe <= 1'b0;                 // last data phase taken
			end
		end
	end
	assign trdy_n = ~(tgt_oe & ~adr_q);
	assign ad_drv = rd_word;
	assign ad_drv_oe = tgt_oe & ~adr_q & ~cmd_seen[0];
endmodule
`default_nettype wire

// file: verification/pcig_glue_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// bench: host accesses, interrupts, master transfers
// ****************************************************************
module pcig_glue_tb_top
	import pcig_pkg::*;
;
	localparam logic [31:0] MEM = 32'h0A000000;
	localparam logic [31:0] IO  = 32'h00C00000;
	int          err_count = 0, cmp_count = 0, cyc = 0;
	logic        sys_clk = 0, srst = 1, h_frame = 1, h_irdy = 1, h_ad_oe = 0, h_idsel = 0;
	logic        dev_seen = 0, endian_big = 0, dac_enable = 0, mst_start = 0, mst_write = 0;
	logic [3:0]  h_cbe = 4'hF, cbe_n_out, cmd_seen;
	logic [7:0]  irq_src = 8'h00, mcnt = 8'h01;
	logic        ab_seen = 0, m66 = 1, mst_abort;
	int          rv_count = 0;
	logic [31:0] h_ad = 32'h0, ad_q = 32'h0, rd, rd_word = 32'h11223344;
	logic [31:0] mst_wdata = 32'hCAFE0001, ad_out, mst_rdata, hi_seen, wr_seen, p_ad;
	logic [63:0] mst_addr = 64'h0;
	logic        ad_oe, cbe_n_oe, frame_n_out, frame_n_oe, irdy_n_out, irdy_n_oe, trdy_n_out;
	logic        trdy_n_oe, devsel_n_out, devsel_n_oe, stop_n_out, stop_n_oe, req_n, gnt_n;
	logic        bus_66mhz, inta_n_out, inta_n_oe, mst_rvalid, mst_done, p_tgt, p_trdy, p_ad_oe;
	// wire levels: control lines pulled up, a released ad bus flips
	wire logic        frame_w = frame_n_oe ? frame_n_out : h_frame;
	wire logic        irdy_w  = irdy_n_oe ? irdy_n_out : h_irdy;
	wire logic        trdy_w  = trdy_n_oe ? trdy_n_out : (p_tgt ? p_trdy : 1'b1);
	wire logic        dev_w   = devsel_n_oe ? devsel_n_out : ~p_tgt;
	wire logic        stop_w  = stop_n_oe ? stop_n_out : 1'b1;
	wire logic [3:0]  cbe_w   = cbe_n_oe ? cbe_n_out : h_cbe;
	wire logic [31:0] ad_w    = ad_oe ? ad_out : h_ad_oe ? h_ad : p_ad_oe ? p_ad : ~ad_q;
	pcig_glue uut (.sys_clk, .srst, .ad_in(ad_w), .ad_out, .ad_oe, .cbe_n_in(cbe_w), .cbe_n_out,
		.cbe_n_oe, .frame_n_in(frame_w), .frame_n_out, .frame_n_oe, .irdy_n_in(irdy_w), .irdy_n_out,
		.irdy_n_oe, .trdy_n_in(trdy_w), .trdy_n_out, .trdy_n_oe, .devsel_n_in(dev_w), .devsel_n_out,
		.devsel_n_oe, .stop_n_in(stop_w), .stop_n_out, .stop_n_oe, .idsel(h_idsel), .gnt_n, .req_n,
		.m66en(m66), .bus_66mhz, .inta_n_out, .inta_n_oe, .io_base(24'h00C000),
		.mem_base(24'h0A0000), .endian_big, .dac_enable, .irq_src, .mst_start, .mst_addr, .mst_write,
		.mst_count(mcnt), .mst_wdata, .mst_wnext(), .mst_rdata, .mst_rvalid, .mst_busy(),
		.mst_done, .mst_abort);
	pcig_bus_partner prt (.sys_clk, .req_n, .frame_n(frame_w), .irdy_n(irdy_w), .cbe_n(cbe_w),
		.ad(ad_w), .rd_word, .gnt_n, .tgt_oe(p_tgt), .trdy_n(p_trdy), .ad_drv(p_ad),
		.ad_drv_oe(p_ad_oe), .cmd_seen, .hi_seen, .wr_seen);
	always #25 sys_clk = ~sys_clk;
	// history of the ad wire, claim monitor and hang guard
	always @(posedge sys_clk) begin
		ad_q <= ad_w;
		cyc++;
		if (devsel_n_oe) dev_seen <= 1'b1;
		if (mst_abort) ab_seen <= 1'b1;
		if (mst_rvalid) rv_count++;
		if (cyc == 3000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// host single-word access; frame held, so the device disconnects
	task automatic tgt(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d,
		input logic sel, output logic [31:0] r);
		int n;
		@(negedge sys_clk);
		{h_frame, h_ad_oe, h_ad, h_cbe, h_idsel} = {2'b01, a, c, sel};
		@(negedge sys_clk);
		{h_irdy, h_cbe, h_ad, h_ad_oe, h_idsel} = {1'b0, BE_ALL, d, c[0], 1'b0};
		for (n = 0; n < 20 && trdy_w !== 1'b0; n++) @(posedge sys_clk);
		r = ad_w;
		@(negedge sys_clk);
		{h_frame, h_irdy, h_ad_oe, h_cbe} = {3'b110, 4'hF};
		repeat (6) @(negedge sys_clk);
	endtask
	// master request from the user side; read word kept when valid
	task automatic mst(input logic [63:0] a, input logic w);
		int n;
		@(negedge sys_clk);
		{mst_addr, mst_write, mst_start} = {a, w, 1'b1};
		@(negedge sys_clk);
		mst_start = 0;
		for (n = 0; n < 80 && mst_done !== 1'b1; n++) begin
			@(posedge sys_clk);
			if (mst_rvalid === 1'b1) rd = mst_rdata;
		end
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic irq(input logic [7:0] s);
		@(negedge sys_clk);
		irq_src = s;
		@(negedge sys_clk);
		irq_src = 8'h00;
		@(negedge sys_clk);
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		srst = 0;
		repeat (3) @(negedge sys_clk);
		chk1(inta_n_oe, 1'b0);
		chk1(inta_n_out, 1'b0);
		chk1(bus_66mhz, 1'b1);
		m66 = 0;
		repeat (3) @(negedge sys_clk);
		chk1(bus_66mhz, 1'b0);
		tgt(CMD_CFG_RD, 32'h0000000C, 32'h0, 1, rd);
		chk32(rd & 32'h0000FF00, 32'h0);
		endian_big = 1;
		tgt(CMD_CFG_WR, 32'h0000000C, 32'h00005A00, 1, rd);
		tgt(CMD_CFG_RD, 32'h0000000C, 32'h0, 1, rd);
		chk32(rd & 32'h0000FF00, 32'h00005A00);
		$display("test config done");
		tgt(CMD_MEM_WR, MEM + 4, 32'h01000080, 0, rd);
		endian_big = 0;
		tgt(CMD_IO_RD, IO + 4, 32'h0, 0, rd);
		chk32(rd, 32'h80000001);
		irq(8'h01);
		chk1(inta_n_oe, 1'b1);
		tgt(CMD_MEM_RD, MEM, 32'h0, 0, rd);
		chk32(rd, 32'h00000001);
		tgt(CMD_IO_WR, IO, 32'h00000001, 0, rd);
		chk1(inta_n_oe, 1'b0);
		irq(8'h02);
		chk1(inta_n_oe, 1'b0);
		tgt(CMD_MEM_WR, MEM + 4, 32'h00000002, 0, rd);
		chk1(inta_n_oe, 1'b0);
		tgt(CMD_MEM_WR, MEM + 4, 32'h80000002, 0, rd);
		chk1(inta_n_oe, 1'b1);
		tgt(CMD_MEM_WR, MEM, 32'h000000FF, 0, rd);
		tgt(CMD_MEM_RD, MEM, 32'h0, 0, rd);
		chk32(rd, 32'h0);
		$display("test interrupt done");
		dev_seen = 0;
		tgt(CMD_DUAL, MEM, 32'h0, 0, rd);
		chk1(dev_seen, 1'b0);
		dac_enable = 1;
		mst(64'h00000001_20000000, 1);
		chk32({28'h0, cmd_seen}, {28'h0, CMD_DUAL});
		chk32(hi_seen, 32'h00000001);
		chk32(wr_seen, 32'hCAFE0001);
		dac_enable = 0;
		endian_big = 1;
		mst(64'h00000001_20000010, 0);
		chk32(rd, 32'h44332211);
		chk32({28'h0, cmd_seen}, {28'h0, CMD_MEM_RD});
		ab_seen = 0;
		mst(64'h00000000_30000000, 1);
		chk1(ab_seen, 1'b1);
		tgt(CMD_CFG_WR, 32'h0000000C, 32'h0, 1, rd);
		mcnt = 8'h02;
		rv_count = 0;
		mst(64'h00000000_20000020, 0);
		chk32(rv_count, 32'h00000001);
		$display("test master done");
		finish_test();
	end
endmodule
`default_nettype wire
